// ### sie_pkg.sv
// package: constants and types for the subtract instruction executor
// Summary of operation
// - opcode 0000 1000 kkkk kkkk: literal minus work register into work register
// - opcode 0101 11da ffff ffff: file register minus work register, two's complement
// - destination bit 0 writes work register, 1 writes back to file register
// - bank bit 0 uses access bank, 1 takes bank from bank select register
// - literal subtract: one word, one cycle, decode/read/process/write in Q1..Q4
// - file subtract: one word, one cycle, decode/read file/process/write in Q1..Q4
// - carry set when result positive or zero, cleared when negative (borrow)
// - zero flag set and negative cleared on zero result, zero cleared otherwise
// - negative result wraps to eight bits; negative flag is result bit 7
package sie_pkg;

  localparam int unsigned DATA_W      = 8;
  localparam int unsigned BANK_W      = 4;
  localparam int unsigned ADDR_W      = 12;
  localparam logic [7:0]  OPC_LIT     = 8'h08;
  localparam logic [5:0]  OPC_FILE    = 6'h17;
  localparam int unsigned BIT_DEST    = 9;
  localparam int unsigned BIT_BANK    = 8;
  localparam logic [7:0]  ACC_SPLIT   = 8'h80;
  localparam logic [3:0]  ACC_LO_BANK = 4'h0;
  localparam logic [3:0]  ACC_HI_BANK = 4'hf;
  localparam logic [7:0]  WORK_RST    = 8'h00;

  typedef enum logic [1:0] {
    SIE_Q1 = 2'b00,
    SIE_Q2 = 2'b01,
    SIE_Q3 = 2'b10,
    SIE_Q4 = 2'b11
  } sie_phase_t;

  typedef struct packed {
    logic negative;
    logic overflow_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } sie_flags_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sie_mem_req_t;

endpackage : sie_pkg

// ### sie_alu.sv
// subtractor: a minus b with status flags
`timescale 1ns/100ps
module sie_alu
  import sie_pkg::*;
(
  input  wire logic [7:0] a_in,
  input  wire logic [7:0] b_in,
  output logic      [7:0] diff_out,
  output sie_pkg::sie_flags_t flags_out
);
  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    full                        = {1'b0, a_in} + {1'b0, ~b_in} + 9'h001;
    low                         = {1'b0, a_in[3:0]} + {1'b0, ~b_in[3:0]} + 5'h01;
    diff_out                    = full[7:0];
    flags_out.carry             = full[8];
    flags_out.digit_carry_flag  = low[4];
    flags_out.zero              = (full[7:0] == 8'h00);
    flags_out.negative          = full[7];
    flags_out.overflow_flag     = (a_in[7] != b_in[7]) && (full[7] != a_in[7]);
  end
endmodule : sie_alu

// ### sie_exec.sv
// top: quarter-phase decode and execution of the two subtract instructions
`timescale 1ns/100ps
module sie_exec
  import sie_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic [15:0]            instr_in,
  input  wire logic [3:0]             bank_select_register_in,
  input  wire logic [7:0]             file_rdata_in,
  output logic [1:0]                  phase_out,
  output logic                        file_rd_out,
  output logic [sie_pkg::ADDR_W-1:0]  file_raddr_out,
  output logic                        file_wr_out,
  output sie_pkg::sie_mem_req_t       file_wreq_out,
  output logic [7:0]                  work_out,
  output sie_pkg::sie_flags_t         flags_out,
  output logic                        flags_wr_out,
  output logic                        done_out
);
  import sie_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sie_phase_t         phase_ff;
  sie_phase_t         nxt_phase;
  logic               is_lit_ff;
  logic               is_file_ff;
  logic               dest_ff;
  logic [ADDR_W-1:0]  addr_ff;
  logic [7:0]         operand_ff;
  logic [7:0]         lit_ff;
  logic [7:0]         diff_ff;
  sie_flags_t         flg_ff;
  logic [7:0]         work_ff;
  logic               rd_ff;
  logic               wr_ff;
  logic               fwr_ff;
  logic               done_ff;
  logic [7:0]         alu_diff;
  sie_flags_t         alu_flags;
  logic [ADDR_W-1:0]  eff_addr;
  logic               lit_dec;
  logic               file_dec;
  logic               run_op;

  // ----------------------------------------------------------------
  // phase sequencing
  // ----------------------------------------------------------------
  always_comb begin
    unique case (phase_ff)
      SIE_Q1: nxt_phase = SIE_Q2;
      SIE_Q2: nxt_phase = SIE_Q3;
      SIE_Q3: nxt_phase = SIE_Q4;
      SIE_Q4: nxt_phase = SIE_Q1;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_ff <= SIE_Q1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // ----------------------------------------------------------------
  // opcode and address decode
  // ----------------------------------------------------------------
  // foreign opcodes decode to neither and leave every output but phase_out alone
  always_comb begin
    lit_dec  = (instr_in[15:8] == OPC_LIT);
    file_dec = (instr_in[15:10] == OPC_FILE);
  end

  always_comb begin
    if (instr_in[BIT_BANK]) begin
      eff_addr = {bank_select_register_in, instr_in[7:0]};
    end else if (instr_in[7:0] < ACC_SPLIT) begin
      eff_addr = {ACC_LO_BANK, instr_in[7:0]};
    end else begin
      eff_addr = {ACC_HI_BANK, instr_in[7:0]};
    end
  end

  // ----------------------------------------------------------------
  // instruction latch in Q1
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      is_lit_ff <= 1'b0;
    end else if (phase_ff == SIE_Q1) begin
      is_lit_ff <= lit_dec;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      is_file_ff <= 1'b0;
    end else if (phase_ff == SIE_Q1) begin
      is_file_ff <= file_dec;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dest_ff <= 1'b0;
    end else if (phase_ff == SIE_Q1 && file_dec) begin
      dest_ff <= instr_in[BIT_DEST];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_ff <= '0;
    end else if (phase_ff == SIE_Q1 && file_dec) begin
      addr_ff <= eff_addr;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lit_ff <= 8'h00;
    end else if (phase_ff == SIE_Q1 && lit_dec) begin
      lit_ff <= instr_in[7:0];
    end
  end

  // decoded subtract held through Q2..Q4
  always_comb begin
    run_op = is_lit_ff || is_file_ff;
  end

  // ----------------------------------------------------------------
  // read, process
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_ff <= 1'b0;
    end else begin
      rd_ff <= (phase_ff == SIE_Q1) && file_dec;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      operand_ff <= 8'h00;
    end else if (phase_ff == SIE_Q2 && run_op) begin
      operand_ff <= is_file_ff ? file_rdata_in : lit_ff;
    end
  end

  sie_alu u_alu (
    .a_in      (operand_ff),
    .b_in      (work_ff),
    .diff_out  (alu_diff),
    .flags_out (alu_flags)
  );

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      diff_ff <= 8'h00;
    end else if (phase_ff == SIE_Q3 && run_op) begin
      diff_ff <= alu_diff;
    end
  end

  // ----------------------------------------------------------------
  // write back in Q4
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      work_ff <= WORK_RST;
    end else if (phase_ff == SIE_Q4 && (is_lit_ff || (is_file_ff && !dest_ff))) begin
      work_ff <= diff_ff;
    end
  end

  // ----------------------------------------------------------------
  // flags and strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flg_ff <= '0;
    end else if (phase_ff == SIE_Q3 && run_op) begin
      flg_ff <= alu_flags;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ff <= 1'b0;
    end else begin
      wr_ff <= (phase_ff == SIE_Q3) && is_file_ff && dest_ff;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fwr_ff <= 1'b0;
    end else begin
      fwr_ff <= (phase_ff == SIE_Q3) && run_op;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (phase_ff == SIE_Q4) && run_op;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign phase_out          = phase_ff;
  assign file_rd_out        = rd_ff;
  assign file_raddr_out     = addr_ff;
  assign file_wr_out        = wr_ff;
  assign file_wreq_out.addr = addr_ff;
  assign file_wreq_out.data = diff_ff;
  assign work_out           = work_ff;
  assign flags_out          = flg_ff;
  assign flags_wr_out       = fwr_ff;
  assign done_out           = done_ff;
endmodule : sie_exec

// ### sie_exec_props.sv
// checker: port-level properties of the subtract executor
`timescale 1ns/100ps
module sie_exec_props
  import sie_pkg::*;
(
  input wire logic                      clk_in,
  input wire logic                      rst_in,
  input wire logic [15:0]               instr_in,
  input wire logic [3:0]                bank_select_register_in,
  input wire logic [7:0]                file_rdata_in,
  input wire logic [1:0]                phase_out,
  input wire logic                      file_rd_out,
  input wire logic [sie_pkg::ADDR_W-1:0] file_raddr_out,
  input wire logic                      file_wr_out,
  input wire logic [7:0]                work_out,
  input wire sie_pkg::sie_flags_t       flags_out,
  input wire logic                      flags_wr_out,
  input wire logic                      done_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic fop, lop;
  assign fop = phase_out == 2'h0 && instr_in[15:10] == OPC_FILE;
  assign lop = phase_out == 2'h0 && instr_in[15:8] == OPC_LIT;
  a_phase_step: assert property (
    !$past(rst_in) |-> phase_out == 2'($past(phase_out) + 2'h1)) else $error("phase stuck");
  a_read_q2: assert property (
    fop |=> file_rd_out && phase_out == 2'h1) else $error("no file read in Q2");
  a_bank_pick: assert property (
    fop |=> file_raddr_out == {($past(instr_in[8]) ? $past(bank_select_register_in)
      : {4{$past(instr_in[7])}}), $past(instr_in[7:0])}) else $error("bad file address");
  a_dest_write: assert property (
    fop |-> ##3 file_wr_out == $past(instr_in[9], 3)) else $error("bad destination");
  a_flags_q4: assert property (
    flags_wr_out |-> phase_out == 2'h3) else $error("flags outside Q4");
  a_done_after: assert property (
    flags_wr_out |=> done_out) else $error("done missing");
  a_lit_result: assert property (
    lop |-> ##4 work_out == 8'($past(instr_in[7:0], 4) - $past(work_out, 4)))
    else $error("bad literal result");
  a_lit_carry: assert property (
    lop |-> ##3 flags_wr_out && flags_out.carry == ($past(instr_in[7:0], 3) >= $past(work_out, 3)))
    else $error("bad carry");
  a_file_zero: assert property (
    file_rd_out |-> ##2 flags_out.zero == ($past(file_rdata_in, 2) == $past(work_out, 2)))
    else $error("bad zero flag");
endmodule : sie_exec_props
bind sie_exec sie_exec_props chk (.clk_in, .rst_in, .instr_in, .bank_select_register_in,
  .file_rdata_in, .phase_out, .file_rd_out, .file_raddr_out, .file_wr_out, .work_out,
  .flags_out, .flags_wr_out, .done_out);

// ### sie_exec_tb.sv
// testbench: runs both subtracts and a foreign opcode
`timescale 1ns/100ps
module sie_exec_tb;
  import sie_pkg::*;
  logic clk_in = 0, rst_in = 1, rd, wr, fwr, done;
  logic [15:0] instr_in = 16'h0000;
  logic [3:0] bank_select_register = 4'h0;
  logic [7:0] rdata = 8'h00, work_out;
  logic [1:0] phase_out;
  logic [11:0] raddr;
  sie_mem_req_t wreq;
  sie_flags_t flags;
  int n_mismatch = 0, n_checks = 0;
  sie_exec uut (.clk_in, .rst_in, .instr_in, .bank_select_register_in(bank_select_register),
    .file_rdata_in(rdata), .phase_out, .file_rd_out(rd), .file_raddr_out(raddr),
    .file_wr_out(wr), .file_wreq_out(wreq), .work_out, .flags_out(flags),
    .flags_wr_out(fwr), .done_out(done));
  initial forever #50 clk_in = ~clk_in;
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic exec(input logic [15:0] ins, input logic [3:0] bs, input logic [7:0] fd,
      input logic [11:0] ea, input logic [7:0] res, ew, input sie_flags_t ef);
    logic fo, ok;
    fo = ins[15:10] == OPC_FILE;
    ok = fo || ins[15:8] == OPC_LIT;
    while (phase_out !== 2'h0) begin
      @(posedge clk_in); #1;
    end
    instr_in = ins;
    bank_select_register = bs;
    @(posedge clk_in); #1;
    chk(rd, fo);
    if (fo || !ok) chk(raddr, ea);
    rdata = fd;
    @(posedge clk_in); #1;
    rdata = ~fd;
    @(posedge clk_in); #1;
    chk(fwr, ok);
    chk(flags, ef);
    chk(wr, fo && ins[9]);
    if ((fo && ins[9]) || !ok) chk(wreq, {ea, res});
    @(posedge clk_in); #1;
    chk(done, ok);
    chk(work_out, ew);
  endtask : exec
  task automatic t_literal;
    exec(16'h0802, 4'h0, 8'h00, 12'h000, 8'h02, 8'h02, 5'b00011);
  endtask : t_literal
  task automatic t_file;
    exec(16'h5c10, 4'h5, 8'h02, 12'h010, 8'h00, 8'h00, 5'b00111);
    exec(16'h0803, 4'h0, 8'h00, 12'h000, 8'h03, 8'h03, 5'b00011);
    exec(16'h5f90, 4'h5, 8'h01, 12'h590, 8'hfe, 8'h03, 5'b10000);
    exec(16'h5e90, 4'h5, 8'h80, 12'hf90, 8'h7d, 8'h03, 5'b01001);
    exec(16'h0802, 4'h0, 8'h00, 12'h000, 8'hff, 8'hff, 5'b10000);
  endtask : t_file
  task automatic t_refused;
    exec(16'hffff, 4'h0, 8'h00, 12'hf90, 8'hff, 8'hff, 5'b10000);
  endtask : t_refused
  task automatic t_reset;
    instr_in = 16'h5e90;
    bank_select_register = 4'h5;
    @(posedge clk_in); #1;
    rst_in = 1;
    @(posedge clk_in); #1;
    rst_in = 0;
    chk(phase_out, 2'h0);
    chk({rd, wr, fwr, done}, 4'h0);
    chk(work_out, WORK_RST);
    chk(flags, 5'b00000);
    chk(raddr, 12'h000);
    chk(wreq, 20'h00000);
    exec(16'h0802, 4'h0, 8'h00, 12'h000, 8'h02, 8'h02, 5'b00011);
  endtask : t_reset
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (400) @(posedge clk_in);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk_in);
    #1 rst_in = 0;
    chk(work_out, 8'h00);
    t_literal();
    t_file();
    t_refused();
    t_reset();
    tally_and_finish();
  end
endmodule : sie_exec_tb
